// ===== design/sca_buf2.sv
`timescale 1ns/100ps
`default_nettype none

// small result buffer; the drain side may stall and the fill side sees it
module sca_buf2 #(
    parameter int W = sca_pkg::DATA_W,
    parameter int DEPTH = sca_pkg::BUF_DEPTH
) (
    input wire logic clk,
    input wire logic rstn,
    sca_stream_if.snk in_if,
    sca_stream_if.src out_if
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
    } sca_buf_s;

    sca_buf_s st_ff;
    sca_buf_s nxt_st;
    logic push;
    logic pop;

    // honest full and empty straight from the fill count
    assign in_if.ready = (st_ff.cnt < (PW+1)'(DEPTH));
    assign out_if.valid = (st_ff.cnt != '0);
    assign out_if.data = st_ff.mem[st_ff.rp];
    assign push = in_if.valid & in_if.ready;
    assign pop = out_if.valid & out_if.ready;

    // pointer and count update
    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wp] = in_if.data;
            nxt_st.wp = (st_ff.wp == PW'(DEPTH-1)) ? '0 : st_ff.wp + 1'b1;
        end
        if (pop) begin
            nxt_st.rp = (st_ff.rp == PW'(DEPTH-1)) ? '0 : st_ff.rp + 1'b1;
        end
        case ({push, pop})
            2'b10: nxt_st.cnt = st_ff.cnt + 1'b1;
            2'b01: nxt_st.cnt = st_ff.cnt - 1'b1;
            default: nxt_st.cnt = st_ff.cnt;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule : sca_buf2

`default_nettype wire

// ===== design/sca_core.sv
// Summary of operation
// [R1] convert-start rising edge samples the input difference as conversion start
// [R2] analog inputs stay disconnected from sampling for the whole conversion
// [R3] conversion timed internally, length varies but stays within min and max
// [R4] at conversion end inputs reconnect, core powers down, result readable
// [R5] serial clock only reads data, and only after conversion has finished
// [R6] result is two's complement code of the differential input
// [R7] serial input high at convert-start rise selects chip-select mode
// [R8] serial input low or tied to convert-start selects daisy-chain mode
// [R9] three-wire select, four-wire select and daisy chain all supported
// [R10] daisy chain passes bits from serial input on to serial output
// [R11] select fall drives MSB, clock falls shift, tristate after 18th or rise
// [R12] host keeps select high through conversion, lowers it only afterwards
// [R13] daisy mode loads 18-bit shifter at conversion end, shifts on falls
// [R14] serial output driven low while serial input and convert-start are low
// [R15] latest result held stable from conversion end to next start
// [R16] mode chosen at convert-start rise holds for conversion and its read
`timescale 1ns/100ps
`default_nettype none

module sca_core (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic convert_start_pin,
    input wire logic din,
    input wire logic [sca_pkg::DATA_W-1:0] positive_analog_input,
    input wire logic [sca_pkg::DATA_W-1:0] negative_analog_input,
    output logic dout,
    output logic dout_oe,
    output logic inputs_connected,
    output logic analog_powered,
    output logic conv_busy,
    output logic cs_mode_sel,
    output logic [sca_pkg::DATA_W-1:0] last_result
);
    localparam int W = sca_pkg::DATA_W;
    localparam int GW = sca_pkg::GRAY_W;

    // state of the core domain outside the result buffer
    typedef struct packed {
        // pin synchronisers and one delayed copy for edges
        logic cs1;
        logic cs2;
        logic csd;
        logic din1;
        logic din2;
        logic dind;
        // analog inputs, staged like any other pin
        logic [W-1:0] p1;
        logic [W-1:0] p2;
        logic [W-1:0] n1;
        logic [W-1:0] n2;
        // edge counter from the link domain and how far it was consumed
        logic [GW-1:0] g1;
        logic [GW-1:0] g2;
        logic [GW-1:0] seen;
        // conversion sequencing
        sca_pkg::sca_state_e st;
        logic [8:0] lfsr;
        logic [8:0] len;
        logic [8:0] tmr;
        logic [W-1:0] smp;
        logic push;
        // serial side
        logic mode_cs;
        logic loaded;
        logic reading;
        logic [4:0] bits;
        logic [W-1:0] sr;
        logic [W-1:0] result;
        // outputs
        logic dout;
        logic oe;
        logic connected;
        logic powered;
        logic busy;
    } sca_core_s;

    sca_core_s st_ff;
    sca_core_s nxt_st;

    logic [GW-1:0] sclk_gray;
    logic [GW-1:0] edge_bin;
    logic cs_rise;
    logic sel_now;
    logic sel_prev;
    logic sel_fall;
    logic sel_rise;
    logic edge_pend;
    logic [W:0] diff;

    sca_stream_if res_in ();
    sca_stream_if res_out ();

    // falling edges of the serial clock, counted in its own domain
    sca_edge_cnt u_edge_cnt (
        .sclk(sclk),
        .rstn(rstn),
        .edge_gray(sclk_gray)
    );

    // finished results wait here until the serial side takes them
    sca_buf2 #(
        .W(W),
        .DEPTH(sca_pkg::BUF_DEPTH)
    ) u_buf (
        .clk(clk),
        .rstn(rstn),
        .in_if(res_in),
        .out_if(res_out)
    );

    function automatic logic [GW-1:0] gray2bin(input logic [GW-1:0] g);
        logic [GW-1:0] b;
        b = '0;
        b[GW-1] = g[GW-1];
        for (int i = GW - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : gray2bin

    // buffer handshakes; one word taken per conversion
    assign res_in.valid = st_ff.push;
    assign res_in.data = st_ff.smp;
    assign res_out.ready = (st_ff.st == sca_pkg::SCA_ST_ACQ) & ~st_ff.loaded;

    // outputs all come from the state register
    assign dout = st_ff.dout;
    assign dout_oe = st_ff.oe;
    assign inputs_connected = st_ff.connected;
    assign analog_powered = st_ff.powered;
    assign conv_busy = st_ff.busy;
    assign cs_mode_sel = st_ff.mode_cs;
    assign last_result = st_ff.result;

    // edge detection on synchronised pins only
    assign cs_rise = st_ff.cs2 & ~st_ff.csd;
    // select is active while either pin is low: convert-start for the
    // three-wire variant, serial input for the four-wire variant
    assign sel_now = ~(st_ff.cs2 & st_ff.din2); // [R9]
    assign sel_prev = ~(st_ff.csd & st_ff.dind);
    assign sel_fall = sel_now & ~sel_prev;
    assign sel_rise = ~sel_now & sel_prev;
    assign edge_bin = gray2bin(st_ff.g2);
    assign edge_pend = (edge_bin != st_ff.seen);
    // difference carries one extra bit, halved back to the word width
    assign diff = {1'b0, st_ff.p2} - {1'b0, st_ff.n2}; // [R6]

    // next state of the core
    always_comb begin
        nxt_st = st_ff;

        // synchroniser chains
        nxt_st.cs1 = convert_start_pin;
        nxt_st.cs2 = st_ff.cs1;
        nxt_st.csd = st_ff.cs2;
        nxt_st.din1 = din;
        nxt_st.din2 = st_ff.din1;
        nxt_st.dind = st_ff.din2;
        nxt_st.p1 = positive_analog_input;
        nxt_st.p2 = st_ff.p1;
        nxt_st.n1 = negative_analog_input;
        nxt_st.n2 = st_ff.n1;
        nxt_st.g1 = sclk_gray;
        nxt_st.g2 = st_ff.g1;
        nxt_st.lfsr = {st_ff.lfsr[7:0], st_ff.lfsr[8] ^ st_ff.lfsr[4]};

        // conversion sequencing
        case (st_ff.st)
            sca_pkg::SCA_ST_ACQ: begin
                if (cs_rise) begin
                    nxt_st.smp = diff[W:1]; // [R1] [R6]
                    // level before the edge, so a serial input tied to
                    // convert-start reads low and picks daisy chain
                    nxt_st.mode_cs = st_ff.dind; // [R7] [R8] [R16]
                    nxt_st.st = sca_pkg::SCA_ST_CONV;
                    nxt_st.tmr = '0;
                    // jitter of up to 255 cycles keeps well under max
                    nxt_st.len = sca_pkg::CONV_MIN_CYC
                        + {1'b0, st_ff.lfsr[7:0]}; // [R3]
                    nxt_st.connected = 1'b0; // [R2]
                    nxt_st.powered = 1'b1;
                    nxt_st.busy = 1'b1;
                    nxt_st.loaded = 1'b0;
                    nxt_st.reading = 1'b0;
                    nxt_st.bits = '0;
                    // chip-select start forces the output off
                    if (st_ff.dind) begin
                        nxt_st.oe = 1'b0; // [R11]
                    end
                end
            end
            sca_pkg::SCA_ST_CONV: begin
                // inputs stay isolated until the count runs out
                nxt_st.tmr = st_ff.tmr + 1'b1; // [R3]
                if (st_ff.tmr == st_ff.len - 1'b1) begin
                    nxt_st.st = sca_pkg::SCA_ST_DONE;
                    nxt_st.push = 1'b1;
                end
            end
            sca_pkg::SCA_ST_DONE: begin
                // a full buffer holds the converter here
                if (res_in.ready) begin
                    nxt_st.push = 1'b0;
                    nxt_st.st = sca_pkg::SCA_ST_ACQ;
                    nxt_st.connected = 1'b1; // [R4]
                    nxt_st.powered = 1'b0; // [R4]
                    nxt_st.busy = 1'b0;
                end
            end
            default: begin
                nxt_st.st = sca_pkg::SCA_ST_ACQ;
                nxt_st.push = 1'b0;
            end
        endcase

        // take the finished word into the output shifter
        if (res_out.valid & res_out.ready) begin
            nxt_st.result = res_out.data; // [R15]
            nxt_st.sr = res_out.data;
            nxt_st.loaded = 1'b1;
            nxt_st.bits = '0;
            if (!st_ff.mode_cs) begin
                // daisy chain drives its MSB at once
                nxt_st.reading = 1'b1; // [R13]
                nxt_st.oe = 1'b1;
                nxt_st.dout = res_out.data[W-1];
            end
        end

        // chip-select read opens on a select fall after conversion;
        // a dip during conversion is ignored by design
        if (st_ff.mode_cs && st_ff.st == sca_pkg::SCA_ST_ACQ
                && st_ff.loaded && sel_fall && st_ff.bits == '0) begin // [R12]
            nxt_st.reading = 1'b1; // [R11]
            nxt_st.oe = 1'b1;
            nxt_st.dout = st_ff.sr[W-1];
        end
        if (st_ff.mode_cs && sel_rise) begin
            nxt_st.reading = 1'b0; // [R11]
            nxt_st.oe = 1'b0;
        end

        // one counted clock fall per cycle, so bursts are not lost
        if (edge_pend) begin
            nxt_st.seen = st_ff.seen + 1'b1;
            // falls outside acquisition only move the pointer
            if (st_ff.st == sca_pkg::SCA_ST_ACQ && nxt_st.reading) begin // [R5]
                nxt_st.sr = {nxt_st.sr[W-2:0],
                    st_ff.mode_cs ? 1'b0 : st_ff.dind}; // [R10] [R13]
                nxt_st.dout = nxt_st.sr[W-1];
                nxt_st.bits = st_ff.bits + 1'b1;
                if (st_ff.mode_cs && st_ff.bits == sca_pkg::BITS_LAST) begin
                    nxt_st.reading = 1'b0; // [R11]
                    nxt_st.oe = 1'b0;
                end
            end
        end

        // both pins low pulls the output low, above all else
        if (!st_ff.cs2 && !st_ff.din2) begin
            nxt_st.dout = 1'b0; // [R14]
            nxt_st.oe = 1'b1;
        end
    end

    // the only clocked process of the core domain outside the result buffer u_buf
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
            st_ff.lfsr <= sca_pkg::LFSR_SEED;
            st_ff.connected <= 1'b1;
            // syncs rest at the idle high level, so release fakes no edge
            st_ff.cs1 <= 1'b1;
            st_ff.cs2 <= 1'b1;
            st_ff.csd <= 1'b1;
            st_ff.din1 <= 1'b1;
            st_ff.din2 <= 1'b1;
            st_ff.dind <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule : sca_core

`default_nettype wire

// ===== design/sca_edge_cnt.sv
`timescale 1ns/100ps
`default_nettype none

// counts serial clock falling edges in the link domain, gray coded
// so the core can sample it without tearing a multi-bit value
module sca_edge_cnt (
    input wire logic sclk,
    input wire logic rstn,
    output logic [sca_pkg::GRAY_W-1:0] edge_gray
);
    typedef struct packed {
        logic [sca_pkg::GRAY_W-1:0] bin;
        logic [sca_pkg::GRAY_W-1:0] gray;
    } sca_cnt_s;

    sca_cnt_s st_ff;
    sca_cnt_s nxt_st;

    assign edge_gray = st_ff.gray;

    // one step per falling edge; the clock may stop between frames
    always_comb begin
        nxt_st = st_ff;
        nxt_st.bin = st_ff.bin + 1'b1;
        nxt_st.gray = nxt_st.bin ^ (nxt_st.bin >> 1);
    end

    always_ff @(negedge sclk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule : sca_edge_cnt

`default_nettype wire

// ===== design/sca_pkg.sv
`default_nettype none

package sca_pkg;

    // word width of one conversion result
    localparam int DATA_W = 18;
    // entries of the result buffer between converter and serial port
    localparam int BUF_DEPTH = 2;
    // width of the falling-edge counter that crosses from the link clock
    localparam int GRAY_W = 5;

    // core clock period and conversion time bounds
    localparam int CLK_PERIOD_NS = 20;
    localparam int T_CONV_MIN_NS = 500;
    localparam int T_CONV_MAX_NS = 8800;
    // least time rounds up, longest time rounds down
    localparam int CONV_MIN_CYC_I =
        (T_CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_MAX_CYC_I = T_CONV_MAX_NS / CLK_PERIOD_NS;
    localparam logic [8:0] CONV_MIN_CYC = 9'(CONV_MIN_CYC_I);
    localparam logic [8:0] CONV_MAX_CYC = 9'(CONV_MAX_CYC_I);

    // pseudo random jitter of the conversion length, never zero
    localparam logic [8:0] LFSR_SEED = 9'h1A5;
    // index of the last bit of a word on the serial output
    localparam logic [4:0] BITS_LAST = 5'h11;

    // converter phase
    typedef enum logic [1:0] {
        SCA_ST_ACQ = 2'b00,
        SCA_ST_CONV = 2'b01,
        SCA_ST_DONE = 2'b10
    } sca_state_e;

endpackage : sca_pkg

`default_nettype wire

// ===== design/sca_stream_if.sv
`timescale 1ns/100ps
`default_nettype none

// one word stream with valid and ready
interface sca_stream_if;
    logic [sca_pkg::DATA_W-1:0] data;
    logic valid;
    logic ready;

    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : sca_stream_if

`default_nettype wire

// ===== test/sar_conversion_and_mode_select_tb.sv
`timescale 1ns/100ps
`default_nettype none

module sar_conversion_and_mode_select_tb;
    localparam int W = sca_pkg::DATA_W;
    logic clk = 1'b0;
    logic rstn;
    logic sclk;
    logic convert_start_pin;
    logic din;
    logic [W-1:0] pos_in;
    logic [W-1:0] neg_in;
    logic dout;
    logic dout_oe;
    logic inputs_connected;
    logic analog_powered;
    logic conv_busy;
    logic cs_mode_sel;
    logic [W-1:0] last_result;
    logic [31:0] rnd_state;
    int n_errors;
    int n_checks;

    sca_core i_dut (
        .clk(clk), .rstn(rstn), .sclk(sclk),
        .convert_start_pin(convert_start_pin), .din(din),
        .positive_analog_input(pos_in), .negative_analog_input(neg_in),
        .dout(dout), .dout_oe(dout_oe), .inputs_connected(inputs_connected),
        .analog_powered(analog_powered), .conv_busy(conv_busy),
        .cs_mode_sel(cs_mode_sel), .last_result(last_result)
    );
    sca_host_model i_host (.sclk(sclk));

    always #10 clk = ~clk;

    function automatic logic [31:0] rnd();
        rnd_state = {rnd_state[30:0], ^(rnd_state & 32'h8020_0003)};
        return rnd_state;
    endfunction : rnd

    // difference kept one bit wider so full scale does not wrap
    function automatic logic [W-1:0] exp_code(logic [W-1:0] p,
                                              logic [W-1:0] n);
        logic [W:0] d;
        d = {1'b0, p} - {1'b0, n};
        return d[W:1];
    endfunction : exp_code

    // inputs always move a fixed 2 ns after the edge
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick

    task automatic check_bit(string what, logic exp, logic got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s exp %b got %b", what, exp, got);
        end
    endtask : check_bit

    task automatic check_word(string what, logic [W-1:0] exp,
                              logic [W-1:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : check_word

    task automatic give_verdict();
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    // one conversion and read; mode 0 three wire, 1 four wire, 2 chain
    task automatic run_cycle(int mode, int corner);
        logic [31:0] r;
        logic [W-1:0] code;
        logic [W+2:0] fedv;
        logic e;
        int cnt;
        r = rnd();
        pos_in = (corner == 1) ? '1 : (corner == 2) ? '0 : r[W-1:0];
        r = rnd();
        neg_in = (corner == 2) ? '1 : (corner == 1) ? '0 : r[W-1:0];
        code = exp_code(pos_in, neg_in);
        din = (mode != 2);
        convert_start_pin = 1'b0;
        tick(3);
        convert_start_pin = 1'b1;
        tick(5);
        check_bit("busy", 1'b1, conv_busy);
        check_bit("isolated", 1'b0, inputs_connected);
        check_bit("powered", 1'b1, analog_powered);
        check_bit("oe in conv", mode == 2, dout_oe);
        // select stays high until the conversion is over
        cnt = 2;
        while (conv_busy === 1'b1 && cnt < 600) begin
            tick(1);
            cnt++;
        end
        if (cnt >= 600) begin
            n_errors++;
            give_verdict();
        end
        check_bit("length", 1'b1, cnt >= sca_pkg::CONV_MIN_CYC_I &&
                  cnt <= sca_pkg::CONV_MAX_CYC_I + 2);
        tick(3);
        check_bit("connected", 1'b1, inputs_connected);
        check_bit("unpowered", 1'b0, analog_powered);
        check_word("result", code, last_result);
        check_bit("mode", mode != 2, cs_mode_sel);
        // select may only fall once the longest conversion has passed
        while (cnt < sca_pkg::CONV_MAX_CYC_I) begin
            tick(1);
            cnt++;
        end
        if (mode == 0) convert_start_pin = 1'b0;
        if (mode == 1) din = 1'b0;
        tick(5);
        check_bit("oe", 1'b1, dout_oe);
        // four wire read is cut short to test an early deselect
        for (int k = 0; k < W + 3; k++) begin
            if ((mode == 1 && k == 10) || (mode == 0 && k == W)) break;
            e = (k < W) ? code[W-1-k] : fedv[k-W];
            check_bit("dout", e, dout);
            r = rnd();
            if (mode == 2) din = r[0];
            fedv[k] = din;
            i_host.pulse();
            tick(5);
        end
        if (mode == 1) din = 1'b1;
        if (mode == 2) convert_start_pin = 1'b0;
        if (mode == 2) din = 1'b0;
        tick(5);
        check_bit("oe end", mode == 2, dout_oe);
        check_bit("dout end", 1'b0, dout & (mode == 2));
        // no rise here: it would start a conversion on stale inputs
        tick(8);
    endtask : run_cycle

    initial begin
        rstn = 1'b0;
        convert_start_pin = 1'b1;
        din = 1'b1;
        pos_in = '0;
        neg_in = '0;
        n_errors = 0;
        n_checks = 0;
        rnd_state = 32'h192A;
        tick(8);
        rstn = 1'b1;
        tick(4);
        check_bit("rst oe", 1'b0, dout_oe);
        check_bit("rst connected", 1'b1, inputs_connected);
        check_word("rst result", '0, last_result);
        // full-scale corners first, then random words in every mode
        run_cycle(0, 1);
        run_cycle(2, 2);
        run_cycle(1, 2);
        for (int i = 0; i < 9; i++) run_cycle(i % 3, 0);
        give_verdict();
    end
endmodule : sar_conversion_and_mode_select_tb

`default_nettype wire

// ===== test/sca_core_asserts.sv
`timescale 1ns/100ps
`default_nettype none

// watches the converter core from its pins only
module sca_core_asserts (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic convert_start_pin,
    input wire logic din,
    input wire logic [sca_pkg::DATA_W-1:0] positive_analog_input,
    input wire logic [sca_pkg::DATA_W-1:0] negative_analog_input,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic inputs_connected,
    input wire logic analog_powered,
    input wire logic conv_busy,
    input wire logic cs_mode_sel,
    input wire logic [sca_pkg::DATA_W-1:0] last_result
);
    logic [8:0] busy_cnt_ff;

    // busy length counter; 9 bits cover the longest legal conversion
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy_cnt_ff <= 9'h000;
        end else if (conv_busy) begin
            busy_cnt_ff <= busy_cnt_ff + 9'h001;
        end else begin
            busy_cnt_ff <= 9'h000;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // sampling switch open while converting
    property p_iso; conv_busy |-> !inputs_connected; endproperty
    a_iso: assert property (p_iso) else $error("inputs seen while busy");
    property p_start;
        $rose(convert_start_pin) && !conv_busy && inputs_connected
            |-> ##3 conv_busy;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_len_min; $fell(conv_busy) |-> busy_cnt_ff >= sca_pkg::CONV_MIN_CYC;
    endproperty
    a_len_min: assert property (p_len_min) else $error("too short");
    property p_len_max; conv_busy |-> busy_cnt_ff < sca_pkg::CONV_MAX_CYC;
    endproperty
    a_len_max: assert property (p_len_max) else $error("too long");
    // select mode output must float during conversion
    property p_cs_tri;
        conv_busy && $past(conv_busy) && cs_mode_sel |-> !dout_oe;
    endproperty
    a_cs_tri: assert property (p_cs_tri) else $error("driven in conv");
    property p_both_low;
        (!convert_start_pin && !din) [*5] |-> dout_oe && !dout;
    endproperty
    a_both_low: assert property (p_both_low) else $error("not low");
    // result changes only just after a conversion ends
    property p_hold;
        $changed(last_result) |-> $past(conv_busy, 2) && !$past(conv_busy);
    endproperty
    a_hold: assert property (p_hold) else $error("result moved");
    property p_mode_cs;
        $rose(convert_start_pin) && !conv_busy && din && $past(din) ##1 din
            |-> ##4 cs_mode_sel;
    endproperty
    a_mode_cs: assert property (p_mode_cs) else $error("not select");
    property p_mode_dc;
        $rose(convert_start_pin) && !conv_busy && !din && !$past(din) ##1 !din
            |-> ##4 !cs_mode_sel;
    endproperty
    a_mode_dc: assert property (p_mode_dc) else $error("not chain");
    property p_daisy_msb;
        $fell(conv_busy) && !cs_mode_sel
            |=> dout_oe && dout == last_result[sca_pkg::DATA_W-1];
    endproperty
    a_daisy_msb: assert property (p_daisy_msb) else $error("no msb");
endmodule : sca_core_asserts

bind sca_core sca_core_asserts i_chk (
    .clk(clk), .rstn(rstn), .sclk(sclk),
    .convert_start_pin(convert_start_pin), .din(din),
    .positive_analog_input(positive_analog_input),
    .negative_analog_input(negative_analog_input),
    .dout(dout), .dout_oe(dout_oe), .inputs_connected(inputs_connected),
    .analog_powered(analog_powered), .conv_busy(conv_busy),
    .cs_mode_sel(cs_mode_sel), .last_result(last_result)
);

`default_nettype wire

// ===== test/sca_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// host serial clock; stands still low outside read frames
module sca_host_model (
    output logic sclk
);
    // half period of the 64 ns link clock
    localparam int HALF_NS = 32;

    // idle low so a chain start never sees a high clock
    initial begin
        sclk = 1'b0;
    end

    // one link clock period ending on a falling edge; called only in
    // acquisition, since shifts during conversion are swallowed
    task automatic pulse();
        #(HALF_NS) sclk = 1'b1;
        #(HALF_NS) sclk = 1'b0;
    endtask : pulse
endmodule : sca_host_model

`default_nettype wire
